// File: logic/ctb_pkg.sv
// Constants and state type of the clock translator status bank
// Assumes a 32-bit classic Wishbone slave, one register per word
//
// Contract
// (R1) System PLL lock lost/gained set bits 5/4
// (R2) Output analog PLL lock lost/gained bits 3/2
// (R3) Calibration started bit 0, ended bit 1
// (R4) ROM load done sets bit 4, 0xD03
// (R5) Distribution sync event sets bit 3
// (R6) Watchdog expiry sets bit 2
// (R7) EEPROM fault bit 1, done bit 0
// (R8) Loop state entries set bits 7 to 4
// (R9) Frequency lock lost bit 3, gained bit 2
// (R10) Phase lock lost bit 1, gained bit 0
// (R11) History update sets bit 4 of 0xD05
// (R12) Frequency clamp on bit 2, off bit 3
// (R13) Slew limiting on bit 0, off bit 1
// (R14) Per reference fault, cleared, validated event flags
// (R15) Live loop state bits in 0xD08
// (R16) Frequency lock bit 5, phase lock bit 4
// (R17) Clamp active bit 5, history available bit 4
// (R18) Active reference priority in bits 3:2
// (R19) Active reference index in bit 0
// (R20) Valid when unfaulted and timer expired, else fault
// (R21) Too fast and too slow bits per reference
// (R22) Unmasked events set sticky flags until cleared
// (R23) Software issues update before reading status
// (R24) Reserved bits and addresses read zero
`default_nettype none
package ctb_pkg;
    // Word indices; byte address is four times the index
    localparam logic [13:0] IDX_SYS_EV   = 14'h0d02;
    localparam logic [13:0] IDX_SYNC_EV  = 14'h0d03;
    localparam logic [13:0] IDX_LOOP_EV  = 14'h0d04;
    localparam logic [13:0] IDX_HIST_EV  = 14'h0d05;
    localparam logic [13:0] IDX_REF_EV   = 14'h0d06;
    localparam logic [13:0] IDX_RSV_EV   = 14'h0d07;
    localparam logic [13:0] IDX_LOOP_ST  = 14'h0d08;
    localparam logic [13:0] IDX_LREF_ST  = 14'h0d09;
    localparam logic [13:0] IDX_RSV_ST   = 14'h0d0a;
    localparam logic [13:0] IDX_IREF_ST  = 14'h0d0b;
    localparam logic [13:0] IDX_RSV_REF  = 14'h0d0c;
    // Mask bytes (1 = masked) and write-one-to-clear bytes
    localparam logic [13:0] IDX_MASK0    = 14'h0e80;
    localparam logic [13:0] IDX_CLR0     = 14'h0e88;
    localparam logic [13:0] IDX_CLR_ALL  = 14'h0e8f;
    localparam int          CLR_ALL_BIT  = 0;
    localparam int          EV_BYTES     = 5;
    localparam logic [7:0]  MASK_RESET   = 8'h00;
    localparam logic [7:0]  EV_RESET     = 8'h00;
    // Order of the watched levels in the edge vector
    localparam int LV_SYS  = 0;
    localparam int LV_OUTPUT_ANALOG_PLL = 1;
    localparam int LV_CAL  = 2;
    localparam int LV_SW   = 3;
    localparam int LV_CLS  = 4;
    localparam int LV_FREE = 5;
    localparam int LV_HOLD = 6;
    localparam int LV_FL   = 7;
    localparam int LV_PL   = 8;
    localparam int LV_CLMP = 9;
    localparam int LV_SLEW = 10;
    localparam int LV_FLTA = 11;
    localparam int LV_VALA = 13;
    localparam int LV_W    = 15;

    typedef struct packed {
        logic [EV_BYTES-1:0][7:0] ev;
        logic [EV_BYTES-1:0][7:0] msk;
        logic [LV_W-1:0]          prev;
        logic                     primed;
        logic                     ack;
        logic [31:0]              dat;
    } ctb_state_s;
endpackage
`default_nettype wire

// File: logic/ctb_status_bank.sv
// Event monitor and status bank of a two-reference clock translator
// Assumes status inputs come from logic on sys_clk; no synchronisers
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ctb_status_bank (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [15:0]             wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    system_clock_pll_locked,
    input  wire logic                    output_analog_pll_locked,
    input  wire logic                    output_analog_pll_cal_busy,
    input  wire logic                    rom_load_done,
    input  wire logic                    dist_sync_event,
    input  wire logic                    watchdog_expired,
    input  wire logic                    eeprom_fault,
    input  wire logic                    eeprom_done,
    input  wire logic                    digital_loop_switching,
    input  wire logic                    digital_loop_closed,
    input  wire logic                    digital_loop_freerun,
    input  wire logic                    digital_loop_holdover,
    input  wire logic                    digital_loop_freq_lock,
    input  wire logic                    digital_loop_phase_lock,
    input  wire logic                    offset_slew_limiting,
    input  wire logic                    history_updated,
    input  wire logic                    history_available,
    input  wire logic                    freq_clamped,
    input  wire logic                    phase_slew_limiting,
    input  wire logic [1:0]              active_ref_priority,
    input  wire logic                    active_ref_index,
    input  wire logic [1:0]              ref_faulted,
    input  wire logic [1:0]              ref_timer_expired,
    input  wire logic [1:0]              ref_too_fast,
    input  wire logic [1:0]              ref_too_slow
);
    import ctb_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic rise(input logic cur, input logic prv);
        rise = cur & ~prv;
    endfunction

    function automatic logic fall(input logic cur, input logic prv);
        fall = ~cur & prv;
    endfunction

    ctb_state_s               q;
    ctb_state_s               d;
    logic [LV_W-1:0]          lv;
    logic [LV_W-1:0]          p;
    logic [1:0]               ref_valid;
    logic [EV_BYTES-1:0][7:0] raw;
    logic [EV_BYTES-1:0][7:0] clr;
    logic [7:0]               st_loop;
    logic [7:0]               st_lref;
    logic [7:0]               st_iref;
    logic [7:0]               rb;
    logic [13:0]              idx;
    logic                     req;
    logic                     wr;

    // ------------------------------------------------------------
    // Live status
    // ------------------------------------------------------------
    assign ref_valid = ~ref_faulted & ref_timer_expired; // R20
    assign st_loop = {1'b0, offset_slew_limiting,
                      digital_loop_freq_lock, digital_loop_phase_lock,
                      digital_loop_switching, digital_loop_holdover,
                      digital_loop_closed, digital_loop_freerun}; // R15 R16
    assign st_lref = {2'b00, freq_clamped, history_available,
                      active_ref_priority, 1'b0,
                      active_ref_index}; // R17 R18 R19
    assign st_iref = {ref_valid[1], ~ref_valid[1], ref_too_fast[1],
                      ref_too_slow[1], ref_valid[0], ~ref_valid[0],
                      ref_too_fast[0], ref_too_slow[0]}; // R20 R21
    assign lv = {ref_valid, ref_faulted, phase_slew_limiting,
                 freq_clamped, digital_loop_phase_lock,
                 digital_loop_freq_lock, digital_loop_holdover,
                 digital_loop_freerun, digital_loop_closed,
                 digital_loop_switching, output_analog_pll_cal_busy,
                 output_analog_pll_locked, system_clock_pll_locked};
    assign p   = q.prev;
    assign idx = wb_adr_i[15:2];
    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr  = req & wb_we_i & wb_sel_i[0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        raw[0] = {2'b00,
                  fall(lv[LV_SYS], p[LV_SYS]),
                  rise(lv[LV_SYS], p[LV_SYS]),             // R1
                  fall(lv[LV_OUTPUT_ANALOG_PLL], p[LV_OUTPUT_ANALOG_PLL]),
                  rise(lv[LV_OUTPUT_ANALOG_PLL], p[LV_OUTPUT_ANALOG_PLL]),           // R2
                  fall(lv[LV_CAL], p[LV_CAL]),
                  rise(lv[LV_CAL], p[LV_CAL])};            // R3
        raw[1] = {3'b000, rom_load_done,                   // R4
                  dist_sync_event,                         // R5
                  watchdog_expired,                        // R6
                  eeprom_fault, eeprom_done};              // R7
        raw[2] = {rise(lv[LV_SW], p[LV_SW]),
                  rise(lv[LV_CLS], p[LV_CLS]),
                  rise(lv[LV_FREE], p[LV_FREE]),
                  rise(lv[LV_HOLD], p[LV_HOLD]),           // R8
                  fall(lv[LV_FL], p[LV_FL]),
                  rise(lv[LV_FL], p[LV_FL]),               // R9
                  fall(lv[LV_PL], p[LV_PL]),
                  rise(lv[LV_PL], p[LV_PL])};              // R10
        raw[3] = {3'b000, history_updated,                 // R11
                  fall(lv[LV_CLMP], p[LV_CLMP]),
                  rise(lv[LV_CLMP], p[LV_CLMP]),           // R12
                  fall(lv[LV_SLEW], p[LV_SLEW]),
                  rise(lv[LV_SLEW], p[LV_SLEW])};          // R13
        raw[4] = {1'b0,
                  rise(lv[LV_VALA+1], p[LV_VALA+1]),
                  fall(lv[LV_FLTA+1], p[LV_FLTA+1]),
                  rise(lv[LV_FLTA+1], p[LV_FLTA+1]),
                  1'b0,
                  rise(lv[LV_VALA], p[LV_VALA]),
                  fall(lv[LV_FLTA], p[LV_FLTA]),
                  rise(lv[LV_FLTA], p[LV_FLTA])};          // R14
        if (!q.primed) begin
            raw = '0;
        end
        clr = '0;
        for (int i = 0; i < EV_BYTES; i++) begin
            if (wr && idx == IDX_CLR0 + 14'(i)) begin
                clr[i] = wb_dat_i[7:0];
            end
            if (wr && idx == IDX_MASK0 + 14'(i)) begin
                d.msk[i] = wb_dat_i[7:0];
            end
        end
        if (wr && idx == IDX_CLR_ALL && wb_dat_i[CLR_ALL_BIT]) begin
            clr = '1;
        end
        for (int i = 0; i < EV_BYTES; i++) begin
            d.ev[i] = (q.ev[i] & ~clr[i]) | (raw[i] & ~q.msk[i]); // R22
        end
        d.prev   = lv;
        d.primed = 1'b1;
        d.ack    = req;
        case (idx)
            IDX_SYS_EV:  rb = q.ev[0];
            IDX_SYNC_EV: rb = q.ev[1];
            IDX_LOOP_EV: rb = q.ev[2];
            IDX_HIST_EV: rb = q.ev[3];
            IDX_REF_EV:  rb = q.ev[4];
            IDX_LOOP_ST: rb = st_loop;
            IDX_LREF_ST: rb = st_lref;
            IDX_IREF_ST: rb = st_iref;
            IDX_MASK0:   rb = q.msk[0];
            IDX_MASK0 + 14'h0001: rb = q.msk[1];
            IDX_MASK0 + 14'h0002: rb = q.msk[2];
            IDX_MASK0 + 14'h0003: rb = q.msk[3];
            IDX_MASK0 + 14'h0004: rb = q.msk[4];
            default:     rb = 8'h00;                        // R24
        endcase
        d.dat = req ? {24'h000000, rb} : 32'h00000000;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q.ev     <= {EV_BYTES{EV_RESET}};
            q.msk    <= {EV_BYTES{MASK_RESET}};
            q.prev   <= '0;
            q.primed <= 1'b0;
            q.ack    <= 1'b0;
            q.dat    <= 32'h00000000;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic clr_any;
    assign clr_any = wr && (idx == IDX_CLR_ALL ||
                     (idx >= IDX_CLR0 && idx < IDX_CLR0 + 14'h0005));

    a_sys_unlock: assert property ( // R1
        q.primed && $fell(system_clock_pll_locked) && !q.msk[0][5]
        |=> q.ev[0][5]) else $error("lost lock flag not set");

    a_output_analog_pll_lock: assert property ( // R2
        q.primed && $rose(output_analog_pll_locked) && !q.msk[0][2]
        |=> q.ev[0][2]) else $error("output_analog_pll lock flag not set");

    a_wdog_event: assert property ( // R6
        q.primed && watchdog_expired && !q.msk[1][2]
        |=> q.ev[1][2]) else $error("watchdog flag not set");

    a_holdover_entry: assert property ( // R8
        q.primed && $rose(digital_loop_holdover) && !q.msk[2][4]
        |=> q.ev[2][4]) else $error("holdover flag not set");

    a_ref_validated: assert property ( // R14
        q.primed && !q.msk[4][6] &&
        $rose(!ref_faulted[1] && ref_timer_expired[1])
        |=> q.ev[4][6]) else $error("ref b validated not set");

    a_flags_sticky: assert property ( // R22
        !clr_any |=> ((q.ev & $past(q.ev)) == $past(q.ev)))
        else $error("event flag dropped without clear");

    a_masked_quiet: assert property ( // R22
        !clr_any && q.msk[1] == 8'hff && q.ev[1] == 8'h00
        |=> q.ev[1] == 8'h00) else $error("masked flag was set");

    a_loop_status: assert property ( // R15
        wb_ack_o && !wb_we_i && idx == IDX_LOOP_ST
        |-> wb_dat_o[7:0] == $past({1'h0, offset_slew_limiting,
            digital_loop_freq_lock, digital_loop_phase_lock,
            digital_loop_switching, digital_loop_holdover,
            digital_loop_closed, digital_loop_freerun}))
        else $error("loop status readback wrong");

    a_ref_status: assert property ( // R20
        wb_ack_o && !wb_we_i && idx == IDX_IREF_ST
        |-> wb_dat_o[7:6] == $past({~ref_faulted[1] & ref_timer_expired[1],
            ref_faulted[1] | ~ref_timer_expired[1]}))
        else $error("ref b status wrong");

    a_rsvd_zero: assert property ( // R24
        wb_ack_o && !wb_we_i && (idx == IDX_RSV_EV ||
        idx == IDX_RSV_ST || idx == IDX_RSV_REF)
        |-> wb_dat_o == 32'h00000000) else $error("reserved not zero");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");

    a_ack_answer: assert property (
        req |=> wb_ack_o) else $error("request not acked");

    a_dat_idle: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("data no ack");

    a_sys_relock: assert property ( // R1
        q.primed && $rose(system_clock_pll_locked) && !q.msk[0][4]
        |=> q.ev[0][4]) else $error("sys lock flag not set");

    a_output_analog_pll_unlock: assert property ( // R2
        q.primed && $fell(output_analog_pll_locked) && !q.msk[0][3]
        |=> q.ev[0][3]) else $error("output_analog_pll unlock flag not set");

    a_cal_start: assert property ( // R3
        q.primed && $rose(output_analog_pll_cal_busy) && !q.msk[0][0]
        |=> q.ev[0][0]) else $error("cal start flag not set");

    a_cal_end: assert property ( // R3
        q.primed && $fell(output_analog_pll_cal_busy) && !q.msk[0][1]
        |=> q.ev[0][1]) else $error("cal end flag not set");

    a_rom_done: assert property ( // R4
        q.primed && rom_load_done && !q.msk[1][4]
        |=> q.ev[1][4]) else $error("rom done flag not set");

    a_sync_event: assert property ( // R5
        q.primed && dist_sync_event && !q.msk[1][3]
        |=> q.ev[1][3]) else $error("sync flag not set");

    a_eeprom_fault: assert property ( // R7
        q.primed && eeprom_fault && !q.msk[1][1]
        |=> q.ev[1][1]) else $error("eeprom fault flag not set");

    a_eeprom_done: assert property ( // R7
        q.primed && eeprom_done && !q.msk[1][0]
        |=> q.ev[1][0]) else $error("eeprom done flag not set");

    a_switch_entry: assert property ( // R8
        q.primed && $rose(digital_loop_switching) && !q.msk[2][7]
        |=> q.ev[2][7]) else $error("switching flag not set");

    a_closed_entry: assert property ( // R8
        q.primed && $rose(digital_loop_closed) && !q.msk[2][6]
        |=> q.ev[2][6]) else $error("closed flag not set");

    a_freerun_entry: assert property ( // R8
        q.primed && $rose(digital_loop_freerun) && !q.msk[2][5]
        |=> q.ev[2][5]) else $error("freerun flag not set");

    a_freq_lost: assert property ( // R9
        q.primed && $fell(digital_loop_freq_lock) && !q.msk[2][3]
        |=> q.ev[2][3]) else $error("freq lost flag not set");

    a_freq_gained: assert property ( // R9
        q.primed && $rose(digital_loop_freq_lock) && !q.msk[2][2]
        |=> q.ev[2][2]) else $error("freq gained flag not set");

    a_phase_lost: assert property ( // R10
        q.primed && $fell(digital_loop_phase_lock) && !q.msk[2][1]
        |=> q.ev[2][1]) else $error("phase lost flag not set");

    a_phase_gained: assert property ( // R10
        q.primed && $rose(digital_loop_phase_lock) && !q.msk[2][0]
        |=> q.ev[2][0]) else $error("phase gained flag not set");

    a_hist_update: assert property ( // R11
        q.primed && history_updated && !q.msk[3][4]
        |=> q.ev[3][4]) else $error("history flag not set");

    a_clamp_on: assert property ( // R12
        q.primed && $rose(freq_clamped) && !q.msk[3][2]
        |=> q.ev[3][2]) else $error("clamp flag not set");

    a_clamp_off: assert property ( // R12
        q.primed && $fell(freq_clamped) && !q.msk[3][3]
        |=> q.ev[3][3]) else $error("unclamp flag not set");

    a_slew_on: assert property ( // R13
        q.primed && $rose(phase_slew_limiting) && !q.msk[3][0]
        |=> q.ev[3][0]) else $error("slew start flag not set");

    a_slew_off: assert property ( // R13
        q.primed && $fell(phase_slew_limiting) && !q.msk[3][1]
        |=> q.ev[3][1]) else $error("slew end flag not set");

    a_ref_fault: assert property ( // R14
        q.primed && $rose(ref_faulted[0]) && !q.msk[4][0]
        |=> q.ev[4][0]) else $error("ref a fault flag not set");

    a_fault_cleared: assert property ( // R14
        q.primed && $fell(ref_faulted[0]) && !q.msk[4][1]
        |=> q.ev[4][1]) else $error("ref a cleared flag not set");

    a_lref_status: assert property ( // R17 R18 R19
        wb_ack_o && !wb_we_i && idx == IDX_LREF_ST
        |-> wb_dat_o[7:0] == $past({2'h0, freq_clamped, history_available,
            active_ref_priority, 1'h0, active_ref_index}))
        else $error("loop reference status wrong");

    a_ref_rates: assert property ( // R21
        wb_ack_o && !wb_we_i && idx == IDX_IREF_ST
        |-> {wb_dat_o[5:4], wb_dat_o[1:0]} == $past({ref_too_fast[1],
            ref_too_slow[1], ref_too_fast[0], ref_too_slow[0]}))
        else $error("reference rate bits wrong");

    c_sys_unlock: cover property (q.ev[0][5] && !$past(q.ev[0][5]));
    c_clear_all: cover property (clr_any && idx == IDX_CLR_ALL);
    c_read_ref: cover property (wb_ack_o && idx == IDX_IREF_ST);
endmodule // ctb_status_bank
`default_nettype wire

// File: testbench/tb_ctb_status_bank.sv
// Self-checking bench of the clock translator status bank
// Assumes the bank answers every Wishbone request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_ctb_status_bank;
    import ctb_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        sys_clk = 1'h0;
    logic        rst     = 1'h1;
    logic        cyc     = 1'h0;
    logic        stb     = 1'h0;
    logic        we      = 1'h0;
    logic [15:0] adr     = 16'h0;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] wdat    = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [10:0] lv      = '0;
    logic [5:0]  pv      = '0;
    logic        offs    = 1'h0;
    logic        hav     = 1'h0;
    logic        aidx    = 1'h0;
    logic [1:0]  prio    = '0;
    logic [1:0]  rf      = '0;
    logic [1:0]  rt      = '0;
    logic [1:0]  rfast   = '0;
    logic [1:0]  rslow   = '0;
    logic [31:0] expq[$];
    logic [31:0] e_h;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          cycles     = 0;

    always #2.5 sys_clk = ~sys_clk;

    ctb_status_bank ctb_status_bank_i (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .system_clock_pll_locked(lv[0]), .output_analog_pll_locked(lv[1]),
        .output_analog_pll_cal_busy(lv[2]), .digital_loop_switching(lv[3]),
        .digital_loop_closed(lv[4]), .digital_loop_freerun(lv[5]),
        .digital_loop_holdover(lv[6]), .digital_loop_freq_lock(lv[7]),
        .digital_loop_phase_lock(lv[8]), .freq_clamped(lv[9]),
        .phase_slew_limiting(lv[10]), .rom_load_done(pv[0]),
        .dist_sync_event(pv[1]), .watchdog_expired(pv[2]),
        .eeprom_fault(pv[3]), .eeprom_done(pv[4]), .history_updated(pv[5]),
        .offset_slew_limiting(offs), .history_available(hav),
        .active_ref_priority(prio), .active_ref_index(aidx),
        .ref_faulted(rf), .ref_timer_expired(rt), .ref_too_fast(rfast),
        .ref_too_slow(rslow)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] ex(input logic [13:0] idx);
        logic va;
        logic vb;
        va = ~rf[0] & rt[0];
        vb = ~rf[1] & rt[1];
        case (idx)
            IDX_LOOP_ST: ex = {25'h0, offs, lv[7], lv[8], lv[3], lv[6],
                               lv[4], lv[5]};
            IDX_LREF_ST: ex = {26'h0, lv[9], hav, prio, 1'h0, aidx};
            IDX_IREF_ST: ex = {24'h0, vb, ~vb, rfast[1], rslow[1],
                               va, ~va, rfast[0], rslow[0]};
            default:     ex = 32'h0;
        endcase
    endfunction

    task automatic bus(input logic [13:0] idx, input logic w,
                       input logic [7:0] d, input logic s0);
        int k;
        @(posedge sys_clk);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= {idx, 2'h0};
        sel  <= {3'h0, s0};
        wdat <= {24'h0, d};
        for (k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'h1) break;
        end
        if (k == 50) `CHK(1'h0, 1'h1)
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
    endtask

    task automatic rd(input logic [13:0] idx, input logic [31:0] e);
        bus(14'h0005, 1'h1, 8'h01, 1'h1);
        expq.push_back(e);
        bus(idx, 1'h0, 8'h0, 1'h1);
    endtask

    task automatic pulse();
        @(posedge sys_clk);
        pv <= '1;
        @(posedge sys_clk);
        pv <= '0;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Read data monitor and timeout
    // ----------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (wb_ack_o === 1'h1 && we === 1'h0) begin
            e_h = (expq.size() > 0) ? expq.pop_front() : 32'hdead_beef;
            `CHK(wb_dat_o, e_h)
        end
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        int i;
        i = $urandom(54);
        repeat (16) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (3) @(posedge sys_clk);
        for (i = IDX_SYS_EV; i <= IDX_RSV_REF; i++)
            rd(i[13:0], ex(i[13:0]));
        rd(14'h0400, 32'h0);
        $display("test reset values done");
        for (i = 0; i < 24; i++) begin
            @(posedge sys_clk);
            {lv, offs, hav, aidx, prio} <= 16'($urandom);
            {rf, rt, rfast, rslow} <= 8'($urandom);
            @(posedge sys_clk);
            rd(IDX_LOOP_ST, ex(IDX_LOOP_ST));
            rd(IDX_LREF_ST, ex(IDX_LREF_ST));
            rd(IDX_IREF_ST, ex(IDX_IREF_ST));
        end
        bus(IDX_LREF_ST, 1'h1, 8'hff, 1'h1);
        rd(IDX_LREF_ST, ex(IDX_LREF_ST));
        $display("test live status done");
        @(posedge sys_clk);
        {lv, offs, hav, aidx, prio, rf, rfast, rslow} <= '0;
        rt <= 2'h3;
        bus(IDX_CLR_ALL, 1'h1, 8'h01, 1'h1);
        for (i = IDX_SYS_EV; i <= IDX_REF_EV; i++) rd(i[13:0], 32'h0);
        @(posedge sys_clk);
        lv <= '1;
        rf <= 2'h3;
        rd(IDX_SYS_EV, 32'h15);
        rd(IDX_LOOP_EV, 32'hf5);
        rd(IDX_HIST_EV, 32'h05);
        rd(IDX_REF_EV, 32'h11);
        @(posedge sys_clk);
        lv <= '0;
        rf <= 2'h0;
        rd(IDX_SYS_EV, 32'h3f);
        rd(IDX_LOOP_EV, 32'hff);
        rd(IDX_HIST_EV, 32'h0f);
        rd(IDX_REF_EV, 32'h77);
        $display("test level events done");
        bus(IDX_MASK0 + 14'h1, 1'h1, 8'hff, 1'h1);
        rd(IDX_MASK0 + 14'h1, 32'hff);
        pulse();
        rd(IDX_SYNC_EV, 32'h0);
        bus(IDX_MASK0 + 14'h1, 1'h1, 8'h00, 1'h1);
        pulse();
        rd(IDX_SYNC_EV, 32'h1f);
        rd(IDX_HIST_EV, 32'h1f);
        bus(IDX_CLR0 + 14'h1, 1'h1, 8'h01, 1'h1);
        bus(IDX_CLR_ALL, 1'h1, 8'h01, 1'h0);
        bus(IDX_SYNC_EV, 1'h1, 8'hff, 1'h1);
        rd(IDX_SYNC_EV, 32'h1e);
        $display("test pulses mask clear done");
        @(posedge sys_clk);
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (3) @(posedge sys_clk);
        rd(IDX_SYNC_EV, 32'h0);
        rd(IDX_HIST_EV, 32'h0);
        $display("test mid-run reset done");
        repeat (3) @(posedge sys_clk);
        `CHK(expq.size(), 0)
        summarize();
    end
endmodule // tb_ctb_status_bank
`default_nettype wire
